/* File: rtl/mpebp_pkg.sv */
/*
  Constants and types used by the device end of the external bus port and its bench:
  data lane placement, word formats, bank decode and arbitration figures.
  Assumes a single clock domain with all inputs synchronous to it.
*/
package mpebp_pkg;

  // Bus widths and counts.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 48;
  localparam int NUM_BANKS = 4;
  localparam int MAX_PROCS = 6;

  // Lane positions for each word format.
  localparam int LANE32_LSB = 16;
  localparam int LANE40_LSB = 8;
  localparam int LANE16_LSB = 16;
  localparam int LANE8_LSB = 16;

  // Reset values for the bank size and page size settings.
  localparam logic [3:0] BANK_SIZE_RST = 4'hC;
  localparam logic [3:0] PAGE_SIZE_RST = 4'h8;

  // Bank decode: bank n starts at BANK_BASE plus n times the bank size.
  localparam logic [31:0] BANK_BASE = 32'h0040_0000;

  // Cycles lost when bus mastership changes hands.
  localparam int HANDOVER_CYCLES = 1;

  // Word formats carried on the data bus.
  typedef enum logic [2:0] {
    MPEBP_FMT_W32,
    MPEBP_FMT_W40,
    MPEBP_FMT_W16,
    MPEBP_FMT_B8
  } mpebp_fmt_t;

endpackage : mpebp_pkg

/* File: rtl/mpebp_if.sv */
/*
  Shared external bus wires between the device end and the other party.
  Two-way pins appear as separate drive, enable and resolved level.
  Assumes the bench resolves any contention; the device drive wins address and data, and strobes are ANDed.
*/
interface mpebp_if;

  // Device-side drive.
  logic [31:0] dev_addr_o;
  logic dev_addr_oe;
  logic [47:0] dev_data_o;
  logic dev_data_oe;
  logic [3:0] dev_bank_select_n;
  logic dev_bank_oe;
  logic dev_rd_n;
  logic dev_wr_n;
  logic dev_sync_write_select_n;
  logic dev_strobe_oe;
  logic dev_page;
  // Other-party drive, then the arbitration flags of both ends.
  logic [31:0] oth_addr_o;
  logic oth_addr_oe;
  logic [47:0] oth_data_o;
  logic oth_data_oe;
  logic oth_rd_n;
  logic oth_wr_n;
  logic oth_sync_write_select_n;
  logic oth_strobe_oe;
  logic bus_tristate_request_n;
  logic dev_bus_req;
  logic oth_bus_req;
  logic dev_grant;

  // Resolved wire levels; undriven strobes idle high.
  logic [31:0] ext_address_bus;
  logic [47:0] ext_data_bus;
  logic rd_n;
  logic wr_n;
  logic sync_write_select_n;
  assign ext_address_bus = dev_addr_oe ? dev_addr_o :
                           (oth_addr_oe ? oth_addr_o : 32'h0000_0000);
  assign ext_data_bus = dev_data_oe ? dev_data_o :
                        (oth_data_oe ? oth_data_o : 48'h0000_0000_0000);
  assign rd_n = (dev_strobe_oe ? dev_rd_n : 1'b1) &
                (oth_strobe_oe ? oth_rd_n : 1'b1);
  assign wr_n = (dev_strobe_oe ? dev_wr_n : 1'b1) &
                (oth_strobe_oe ? oth_wr_n : 1'b1);
  assign sync_write_select_n =
    (dev_strobe_oe ? dev_sync_write_select_n : 1'b1) &
    (oth_strobe_oe ? oth_sync_write_select_n : 1'b1);

  modport device (
    output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe,
    output dev_bank_select_n, dev_bank_oe, dev_rd_n, dev_wr_n,
    output dev_sync_write_select_n, dev_strobe_oe, dev_page,
    output dev_bus_req, dev_grant,
    input ext_address_bus, ext_data_bus, rd_n, wr_n, sync_write_select_n,
    input bus_tristate_request_n, oth_bus_req
  );

  modport other (
    output oth_addr_o, oth_addr_oe, oth_data_o, oth_data_oe,
    output oth_rd_n, oth_wr_n, oth_sync_write_select_n, oth_strobe_oe,
    output bus_tristate_request_n, oth_bus_req,
    input ext_address_bus, ext_data_bus, rd_n, wr_n, sync_write_select_n,
    input dev_bank_select_n, dev_page, dev_grant, dev_bus_req
  );

endinterface : mpebp_if

/* File: rtl/mpebp_lane.sv */
/*
  Lane placement helper: puts a word of a given format onto its data bus
  lanes and takes it back off. Purely combinational.
  Assumes the word is right-aligned in a 48-bit carrier.
*/
module mpebp_lane (
  // Format and words.
  input wire mpebp_pkg::mpebp_fmt_t fmt,
  input wire logic [47:0] word_in,
  input wire logic [47:0] bus_in,
  // Placed and extracted values.
  output logic [47:0] bus_out,
  output logic [47:0] word_out
);

  // Place and extract per format; unused lanes stay at zero.
  always_comb begin
    bus_out = 48'h0000_0000_0000;
    word_out = 48'h0000_0000_0000;
    unique case (fmt)
      mpebp_pkg::MPEBP_FMT_W32: begin
        bus_out[47:16] = word_in[31:0]; // R1
        word_out[31:0] = bus_in[47:16]; // R1
      end
      mpebp_pkg::MPEBP_FMT_W40: begin
        bus_out[47:8] = word_in[39:0]; // R2
        word_out[39:0] = bus_in[47:8]; // R2
      end
      mpebp_pkg::MPEBP_FMT_W16: begin
        bus_out[31:16] = word_in[15:0]; // R3
        word_out[15:0] = bus_in[31:16]; // R3
      end
      mpebp_pkg::MPEBP_FMT_B8: begin
        bus_out[23:16] = word_in[7:0]; // R4
        word_out[7:0] = bus_in[23:16]; // R4
      end
      default: begin
        bus_out = 48'h0000_0000_0000;
        word_out = 48'h0000_0000_0000;
      end
    endcase
  end

endmodule : mpebp_lane

/* File: rtl/mpebp_device.sv */
/*
  Device end of the external bus port. As master it runs two-cycle
  accesses for its user side; as slave it accepts accesses from a host
  or peer into its internal memory. Arbitrates with one other party.
  Assumes all bus inputs are synchronous to CLK.
*/
// Overview of operation
// R1 - 32-bit words on data bits 47..16
// R2 - 40-bit words on data bits 47..8
// R3 - 16-bit words on data bits 31..16
// R4 - boot bytes on data bits 23..16
// R5 - four active-low bank selects, sized by setting
// R6 - bank selects change with address outputs
// R7 - selects idle without access, kept if condition false
// R8 - read strobe asserted on device reads
// R9 - outside master asserts read strobe to read
// R10 - write strobe asserted on device writes
// R11 - outside master asserts write strobe to write
// R12 - only current master drives strobes
// R13 - accept address when outside master accesses memory
// R14 - page output on DRAM page crossing
// R15 - page output only for bank zero
// R16 - early sync write select, aborted without strobe
// R17 - sync write select with address
// R18 - slaves use sync write select for direction
// R19 - host asserts sync write select on writes
// R20 - release outputs on tristate request or slave
// R21 - arbitration, fixed or rotating, one-cycle handover
// R22 - bus lock keeps bus for read-modify-write
module mpebp_device #(
  parameter int MEM_WORDS = 64
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Shared bus.
  mpebp_if.device BUS,
  // Settings.
  input wire logic [3:0] BANK_SIZE_FIELD,
  input wire logic [3:0] PAGE_SIZE,
  input wire logic ROTATE_PRIO,
  input wire logic BUS_LOCK,
  // Master request from the user side.
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic REQ_COND_TRUE,
  input wire mpebp_pkg::mpebp_fmt_t REQ_FMT,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [47:0] REQ_WDATA,
  // Master answer.
  output logic RSP_VALID,
  output logic [47:0] RSP_RDATA,
  // Status.
  output logic IS_MASTER
);

  // Refuse sizes that the low address bits cannot index exactly.
  if (MEM_WORDS < 2 || MEM_WORDS > 4096 ||
      (1 << $clog2(MEM_WORDS)) != MEM_WORDS) begin : g_bad_mem_words
    $error("MEM_WORDS must be a power of two from 2 to 4096");
  end
  localparam int MEM_AW = $clog2(MEM_WORDS);

  typedef enum logic [1:0] {
    MPEBP_IDLE, MPEBP_ADDR, MPEBP_STROBE, MPEBP_HANDOVER
  } mpebp_state_t;

  mpebp_state_t state_reg;
  logic master_reg;
  logic rot_last_dev_reg;
  logic write_reg;
  logic cond_reg;
  logic [31:0] addr_reg;
  logic [47:0] wdata_reg;
  logic [3:0] bank_sel_n_reg;
  logic page_reg;
  logic [31:0] last_page_reg;
  logic rsp_valid_reg;
  logic [47:0] rdata_reg;
  mpebp_pkg::mpebp_fmt_t fmt_reg;
  logic [47:0] mem [MEM_WORDS];
  logic [47:0] bus_word;
  logic [47:0] rd_word;
  logic want_bus;
  logic grant;
  logic slave_rd;
  logic slave_wr;
  logic [3:0] bank_next;
  logic [31:0] page_next;
  logic drive_en;

  // Lane placement for outgoing writes and incoming reads.
  mpebp_lane u_lane (
    .fmt(fmt_reg),
    .word_in(wdata_reg),
    .bus_in(BUS.ext_data_bus),
    .bus_out(bus_word),
    .word_out(rd_word)
  );

  // Bank decode from the request address; banks are contiguous blocks.
  always_comb begin
    bank_next = 4'hF;
    for (int b = 0; b < mpebp_pkg::NUM_BANKS; b++) begin
      if (REQ_ADDR[31:26] == 6'h00 &&
          REQ_ADDR >= mpebp_pkg::BANK_BASE &&
          (REQ_ADDR - mpebp_pkg::BANK_BASE) >> BANK_SIZE_FIELD ==
            32'(b)) begin
        bank_next[b] = 1'b0; // R5
      end
    end
    page_next = REQ_ADDR >> PAGE_SIZE;
  end

  // Arbitration: fixed gives the device priority; rotating alternates.
  always_comb begin
    want_bus = REQ_VALID || (BUS_LOCK && master_reg);
    if (master_reg && BUS_LOCK) begin
      grant = 1'b1; // R22
    end else if (!BUS.oth_bus_req) begin
      grant = want_bus;
    end else if (!want_bus) begin
      grant = 1'b0;
    end else begin
      grant = ROTATE_PRIO ? !rot_last_dev_reg : 1'b1; // R21
    end
  end

  // Master state machine; a change of owner costs one handover cycle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= MPEBP_IDLE;
      master_reg <= 1'b0;
      rot_last_dev_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MPEBP_IDLE: begin
          if (grant != master_reg) begin
            state_reg <= MPEBP_HANDOVER; // R21
          end else if (master_reg && REQ_VALID &&
                       BUS.bus_tristate_request_n) begin
            state_reg <= MPEBP_ADDR;
            rot_last_dev_reg <= 1'b1;
          end
        end
        MPEBP_HANDOVER: begin
          master_reg <= grant;
          if (!grant) begin
            rot_last_dev_reg <= 1'b0;
          end
          state_reg <= MPEBP_IDLE;
        end
        MPEBP_ADDR: state_reg <= MPEBP_STROBE;
        MPEBP_STROBE: state_reg <= MPEBP_IDLE;
      endcase
    end
  end

  // Capture the access; address, selects and sync write change together.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      write_reg <= 1'b0;
      cond_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 48'h0000_0000_0000;
      fmt_reg <= mpebp_pkg::MPEBP_FMT_W32;
      bank_sel_n_reg <= 4'hF;
      page_reg <= 1'b0;
      last_page_reg <= 32'hFFFF_FFFF;
    end else if (state_reg == MPEBP_IDLE && master_reg && REQ_VALID &&
                 BUS.bus_tristate_request_n && grant) begin
      write_reg <= REQ_WRITE;
      cond_reg <= REQ_COND_TRUE;
      addr_reg <= REQ_ADDR;
      wdata_reg <= REQ_WDATA;
      fmt_reg <= REQ_FMT;
      bank_sel_n_reg <= bank_next; // R6 R7
      page_reg <= !bank_next[0] && page_next != last_page_reg; // R14 R15
      if (!bank_next[0]) begin
        last_page_reg <= page_next; // R15
      end
    end else if (state_reg == MPEBP_STROBE) begin
      bank_sel_n_reg <= 4'hF; // R7
      page_reg <= 1'b0;
    end
  end

  // Answer to the user side, one cycle after the strobe cycle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rsp_valid_reg <= 1'b0;
      rdata_reg <= 48'h0000_0000_0000;
    end else begin
      rsp_valid_reg <= state_reg == MPEBP_STROBE;
      if (state_reg == MPEBP_STROBE && !write_reg && cond_reg) begin
        rdata_reg <= rd_word; // R8
      end
    end
  end

  // Slave side: the outside master's strobes and sync write select.
  assign slave_rd = !master_reg && !BUS.rd_n; // R9 R13
  assign slave_wr = !master_reg && !BUS.wr_n &&
                    !BUS.sync_write_select_n; // R11 R18 R19

  // Internal memory written by outside masters.
  always_ff @(posedge CLK) begin
    if (slave_wr) begin
      mem[BUS.ext_address_bus[MEM_AW-1:0]] <= BUS.ext_data_bus; // R13
    end
  end

  // Outputs other than slave read data are released while slave or while tristate is requested.
  assign drive_en = master_reg && BUS.bus_tristate_request_n; // R12 R20
  assign BUS.dev_addr_oe = drive_en && state_reg != MPEBP_HANDOVER;
  assign BUS.dev_addr_o = addr_reg;
  assign BUS.dev_bank_oe = drive_en;
  assign BUS.dev_bank_select_n = bank_sel_n_reg;
  assign BUS.dev_strobe_oe = drive_en; // R12
  assign BUS.dev_sync_write_select_n =
    !(write_reg && (state_reg == MPEBP_ADDR ||
      state_reg == MPEBP_STROBE)); // R16 R17
  assign BUS.dev_rd_n = !(state_reg == MPEBP_STROBE && !write_reg &&
                          cond_reg); // R8
  // A false conditional write leaves the strobe high and so aborts.
  assign BUS.dev_wr_n = !(state_reg == MPEBP_STROBE && write_reg &&
                          cond_reg); // R10 R16
  assign BUS.dev_page = page_reg;
  // Slave read data goes out while the outside master holds the strobe.
  assign BUS.dev_data_oe = (drive_en && write_reg &&
                            state_reg == MPEBP_STROBE) ||
                           (slave_rd && BUS.bus_tristate_request_n); // R20
  assign BUS.dev_data_o = master_reg ? bus_word :
                          mem[BUS.ext_address_bus[MEM_AW-1:0]];
  assign BUS.dev_bus_req = want_bus;
  assign BUS.dev_grant = master_reg;

  assign REQ_READY = state_reg == MPEBP_IDLE && master_reg &&
                     BUS.bus_tristate_request_n && grant;
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_RDATA = rdata_reg;
  assign IS_MASTER = master_reg;

endmodule : mpebp_device

/* File: rtl/mpebp_other.sv */
/*
  Other party's end: a host or peer that, while the device is slave,
  reads and writes the device's internal memory over the shared bus.
  Assumes the device drives its grant flag; host owns the bus while the device neither holds nor requests it.
*/
module mpebp_other (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Shared bus.
  mpebp_if.other BUS,
  // User side.
  input wire logic TRISTATE_REQ,
  input wire logic WANT_BUS,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [47:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [47:0] RSP_RDATA
);

  typedef enum logic [1:0] {MPEBP_O_IDLE, MPEBP_O_ADDR, MPEBP_O_STROBE}
    mpebp_ostate_t;

  mpebp_ostate_t state_reg;
  logic write_reg;
  logic [31:0] addr_reg;
  logic [47:0] wdata_reg;
  logic rsp_valid_reg;
  logic [47:0] rdata_reg;
  logic owns;

  assign owns = !BUS.dev_grant && !BUS.dev_bus_req;

  // Access sequencer: address with sync write, then the strobe.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= MPEBP_O_IDLE;
      write_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 48'h0000_0000_0000;
    end else begin
      unique case (state_reg)
        MPEBP_O_IDLE: begin
          if (REQ_VALID && owns) begin
            state_reg <= MPEBP_O_ADDR;
            write_reg <= REQ_WRITE;
            addr_reg <= REQ_ADDR;
            wdata_reg <= REQ_WDATA;
          end
        end
        MPEBP_O_ADDR: state_reg <= MPEBP_O_STROBE;
        MPEBP_O_STROBE: state_reg <= MPEBP_O_IDLE;
      endcase
    end
  end

  // Read data is caught at the end of the strobe cycle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rsp_valid_reg <= 1'b0;
      rdata_reg <= 48'h0000_0000_0000;
    end else begin
      rsp_valid_reg <= state_reg == MPEBP_O_STROBE;
      if (state_reg == MPEBP_O_STROBE && !write_reg) begin
        rdata_reg <= BUS.ext_data_bus;
      end
    end
  end

  // Drive the bus only while an access is under way.
  assign BUS.oth_strobe_oe = state_reg != MPEBP_O_IDLE;
  assign BUS.oth_addr_oe = state_reg != MPEBP_O_IDLE;
  assign BUS.oth_addr_o = addr_reg;
  assign BUS.oth_sync_write_select_n = !write_reg; // R19
  assign BUS.oth_rd_n = !(state_reg == MPEBP_O_STROBE && !write_reg); // R9
  assign BUS.oth_wr_n = !(state_reg == MPEBP_O_STROBE && write_reg); // R11
  assign BUS.oth_data_oe = state_reg == MPEBP_O_STROBE && write_reg;
  assign BUS.oth_data_o = wdata_reg;
  assign BUS.bus_tristate_request_n = !TRISTATE_REQ; // R20
  assign BUS.oth_bus_req = WANT_BUS;

  assign REQ_READY = state_reg == MPEBP_O_IDLE && owns;
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_RDATA = rdata_reg;

endmodule : mpebp_other

/* File: bench/mpebp_assertions.sv */
/*
  Checker for the device end of the shared external bus.
  Assumes it sits beside the interface and sees its signals directly.
*/
module mpebp_assertions (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Device drives.
  input wire logic dev_addr_oe,
  input wire logic dev_data_oe,
  input wire logic [3:0] dev_bank_select_n,
  input wire logic dev_rd_n,
  input wire logic dev_wr_n,
  input wire logic dev_sync_write_select_n,
  input wire logic dev_strobe_oe,
  input wire logic dev_page,
  input wire logic dev_grant,
  // Other-party drive and resolved read strobe.
  input wire logic bus_tristate_request_n,
  input wire logic rd_n
);
  // All checks share the one clock and reset.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // A select is only low for one bank, and only with a driven address.
  AST_SEL_ONE_BANK: assert property (
    dev_bank_select_n != 4'hF |-> $onehot(~dev_bank_select_n) && dev_addr_oe)
    else $error("bank select not one bank with address");
  // Selects stand through the address and strobe cycles, then idle.
  AST_SEL_HOLD: assert property (
    $changed(dev_bank_select_n) && dev_bank_select_n != 4'hF
    |=> $stable(dev_bank_select_n) ##1 dev_bank_select_n == 4'hF)
    else $error("bank select did not stand two cycles");
  // A read strobe lasts one cycle under a driven address, no early write.
  AST_RD_PULSE: assert property (
    dev_strobe_oe && !dev_rd_n |-> dev_addr_oe && dev_sync_write_select_n
    ##1 (dev_rd_n || !dev_strobe_oe))
    else $error("read strobe malformed");
  // A write strobe is always preceded by the early write indication.
  AST_WR_AFTER_SW: assert property (
    dev_strobe_oe && !dev_wr_n |-> !dev_sync_write_select_n &&
    $past(!dev_sync_write_select_n) && dev_data_oe)
    else $error("write strobe without early write indication");
  // The early write indication starts in the address cycle.
  AST_SW_WITH_ADDR: assert property (
    $fell(dev_sync_write_select_n) |-> dev_addr_oe &&
    dev_bank_select_n != 4'hF)
    else $error("early write indication without address");
  // A slave only answers an outside read strobe with data.
  AST_SLAVE_RELEASED: assert property (
    !dev_grant |-> !dev_addr_oe && !dev_strobe_oe &&
    (!dev_data_oe || !rd_n))
    else $error("slave device drives the bus");
  // Checked after two request cycles; the release itself follows the request in the same cycle.
  AST_TRISTATE: assert property (
    !bus_tristate_request_n [*2] |-> !dev_addr_oe && !dev_data_oe &&
    !dev_strobe_oe)
    else $error("bus driven under tristate request");
  // Page crossing is only ever shown for bank zero.
  AST_PAGE_BANK0: assert property (
    dev_page |-> !dev_bank_select_n[0])
    else $error("page output outside bank zero");
  // Page crossing stands for the address and strobe cycles only.
  AST_PAGE_PULSE: assert property (
    $rose(dev_page) |=> dev_page ##1 !dev_page)
    else $error("page output length wrong");
endmodule : mpebp_assertions

/* File: bench/multiprocessor_external_bus_port_test.sv */
/*
  Self-checking bench: both ends joined by the shared bus interface.
  Assumes one 200 MHz clock; inputs move 1 ns after the rising edge.
*/
module multiprocessor_external_bus_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_lock = 1'b0, d_valid = 1'b0, d_write = 1'b0, d_cond = 1'b1;
  logic o_tri = 1'b0, o_want = 1'b0, o_valid = 1'b0, o_write = 1'b0;
  logic rot = 1'b0;
  logic d_ready, d_rsp, d_master, o_ready, o_rsp;
  logic [31:0] d_addr = 32'h0, o_addr = 32'h0, seen_addr, a;
  logic [47:0] d_wdata = 48'h0, o_wdata = 48'h0, d_rdata, o_rdata;
  logic [47:0] seen_data;
  logic [3:0] seen_sel;
  logic seen_wr, seen_rd, seen_sw, seen_page;
  mpebp_pkg::mpebp_fmt_t d_fmt = mpebp_pkg::MPEBP_FMT_W32;
  int mismatches = 0;
  int comparisons = 0;
  int k, n;

  // Clock.
  always #2.5 clk = ~clk;

  mpebp_if bus_if ();
  mpebp_device i_mpebp_device (.CLK(clk), .RSTN(rstn), .BUS(bus_if.device),
    .BANK_SIZE_FIELD(4'h4), .PAGE_SIZE(4'h2), .ROTATE_PRIO(rot),
    .BUS_LOCK(bus_lock), .REQ_VALID(d_valid), .REQ_READY(d_ready),
    .REQ_WRITE(d_write), .REQ_COND_TRUE(d_cond), .REQ_FMT(d_fmt),
    .REQ_ADDR(d_addr), .REQ_WDATA(d_wdata), .RSP_VALID(d_rsp),
    .RSP_RDATA(d_rdata), .IS_MASTER(d_master));
  mpebp_other i_mpebp_other (.CLK(clk), .RSTN(rstn), .BUS(bus_if.other),
    .TRISTATE_REQ(o_tri), .WANT_BUS(o_want), .REQ_VALID(o_valid),
    .REQ_READY(o_ready), .REQ_WRITE(o_write), .REQ_ADDR(o_addr),
    .REQ_WDATA(o_wdata), .RSP_VALID(o_rsp), .RSP_RDATA(o_rdata));
  mpebp_assertions i_mpebp_assertions (.CLK(clk), .RSTN(rstn),
    .dev_addr_oe(bus_if.dev_addr_oe), .dev_data_oe(bus_if.dev_data_oe),
    .dev_bank_select_n(bus_if.dev_bank_select_n),
    .dev_rd_n(bus_if.dev_rd_n), .dev_wr_n(bus_if.dev_wr_n),
    .dev_sync_write_select_n(bus_if.dev_sync_write_select_n),
    .dev_strobe_oe(bus_if.dev_strobe_oe), .dev_page(bus_if.dev_page),
    .dev_grant(bus_if.dev_grant),
    .bus_tristate_request_n(bus_if.bus_tristate_request_n),
    .rd_n(bus_if.rd_n));

  // Verdict and end of run.
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // A bound ran out: count it and stop.
  task automatic timeout;
    mismatches++;
    $display("unexpected at %0t: wait bound %h expected %h", $time, 0, 1);
    finish_test();
  endtask : timeout

  // Compare one value; an unknown bit matches only an unknown bit.
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Expected wire image of a right-aligned word.
  function automatic logic [47:0] place(input mpebp_pkg::mpebp_fmt_t f,
      input logic [47:0] w);
    case (f)
      mpebp_pkg::MPEBP_FMT_W32: place = 48'(w[31:0]) << mpebp_pkg::LANE32_LSB;
      mpebp_pkg::MPEBP_FMT_W40: place = 48'(w[39:0]) << mpebp_pkg::LANE40_LSB;
      mpebp_pkg::MPEBP_FMT_W16: place = 48'(w[15:0]) << mpebp_pkg::LANE16_LSB;
      default: place = 48'(w[7:0]) << mpebp_pkg::LANE8_LSB;
    endcase
  endfunction : place

  // Record what the wires show in one settled half cycle.
  task automatic sample;
    if (bus_if.dev_bank_select_n !== 4'hF) begin
      seen_sel = bus_if.dev_bank_select_n;
      seen_addr = bus_if.ext_address_bus;
    end
    if (bus_if.wr_n === 1'b0) begin
      seen_wr = 1'b1;
      seen_data = bus_if.ext_data_bus;
    end
    if (bus_if.rd_n === 1'b0) seen_rd = 1'b1;
    if (bus_if.sync_write_select_n === 1'b0) seen_sw = 1'b1;
    if (bus_if.dev_page === 1'b1) seen_page = 1'b1;
  endtask : sample

  // One transfer from either end; the request holds until taken.
  task automatic op(input logic dev, input logic wr, input logic cond,
      input mpebp_pkg::mpebp_fmt_t fmt, input logic [31:0] ad,
      input logic [47:0] d);
    int i;
    @(posedge clk);
    #1;
    d_valid = dev;
    o_valid = !dev;
    d_write = wr;
    o_write = wr;
    d_cond = cond;
    d_fmt = fmt;
    d_addr = ad;
    o_addr = ad;
    d_wdata = d;
    o_wdata = d;
    i = 0;
    @(negedge clk);
    while ((dev ? d_ready : o_ready) !== 1'b1) begin
      i++;
      if (i > 40) timeout();
      @(negedge clk);
    end
    @(posedge clk);
    #1;
    d_valid = 1'b0;
    o_valid = 1'b0;
    {seen_sel, seen_wr, seen_rd, seen_sw, seen_page} = 8'hF0;
    seen_data = 48'h0;
    for (i = 0; i < 8 && (dev ? d_rsp : o_rsp) !== 1'b1; i++) begin
      @(negedge clk);
      sample();
    end
    if ((dev ? d_rsp : o_rsp) !== 1'b1) timeout();
  endtask : op

  // Main sequence: slave traffic, master traffic, tristate, lock.
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (k = 0; k < 2; k++) begin
      op(0, 1, 1, d_fmt, 32'(k + 5), 48'hA5A5_0000_0000 | 48'(k));
      check(48'({seen_wr, seen_sw}), 48'h3);
    end
    for (k = 0; k < 2; k++) begin
      op(0, 0, 1, d_fmt, 32'(k + 5), 48'h0);
      check(o_rdata, 48'hA5A5_0000_0000 | 48'(k));
      check(48'(seen_sw), 48'h0);
    end
    for (k = 0; k < 4; k++) begin
      a = mpebp_pkg::BANK_BASE + 32'(k * 16) + 32'h1;
      op(1, 1, 1, mpebp_pkg::mpebp_fmt_t'(k), a, 48'hFEDC_BA98_7654);
      check(seen_data, place(mpebp_pkg::mpebp_fmt_t'(k),
        48'hFEDC_BA98_7654));
      check({44'h0, seen_sel}, {44'h0, ~(4'h1 << k)});
      check(48'(seen_addr), 48'(a));
      check(48'(seen_page), 48'(k == 0));
    end
    check(48'(d_master), 48'h1);
    // Same page twice, then the next page of four words.
    for (k = 0; k < 2; k++) begin
      op(1, 1, 1, d_fmt, mpebp_pkg::BANK_BASE + 32'(2 + 3 * k), 48'h1);
      check(48'(seen_page), 48'(k));
    end
    op(1, 0, 1, d_fmt, mpebp_pkg::BANK_BASE + 32'h3, 48'h0);
    check(48'({seen_rd, seen_wr, seen_sw}), 48'h4);
    op(1, 1, 0, d_fmt, mpebp_pkg::BANK_BASE + 32'h12, 48'h7);
    check(48'({seen_sel, seen_sw, seen_wr}), 48'h36);
    // Tristate request holds off a pending device request and its drive.
    @(posedge clk);
    #1;
    o_tri = 1'b1;
    d_valid = 1'b1;
    n = 0;
    repeat (6) @(negedge clk) n += int'(d_ready === 1'b1 ||
      bus_if.dev_strobe_oe !== 1'b0 || bus_if.dev_addr_oe !== 1'b0);
    check(48'(n), 48'h0);
    @(posedge clk);
    #1;
    d_valid = 1'b0;
    o_tri = 1'b0;
    op(1, 1, 1, d_fmt, mpebp_pkg::BANK_BASE + 32'h21, 48'h9);
    check(48'(seen_wr), 48'h1);
    // A locked bus is kept against the other party's request.
    @(posedge clk);
    #1;
    bus_lock = 1'b1;
    o_want = 1'b1;
    n = 0;
    repeat (10) @(negedge clk) n += int'(d_master === 1'b1);
    check(48'(n), 48'd10);
    @(posedge clk);
    #1;
    bus_lock = 1'b0;
    for (k = 0; k < 20 && d_master !== 1'b0; k++) @(negedge clk);
    check(48'(d_master), 48'h0);
    op(0, 0, 1, d_fmt, 32'h5, 48'h0);
    check(o_rdata, 48'hA5A5_0000_0000);
    @(posedge clk);
    #1;
    o_want = 1'b0;
    op(1, 1, 1, d_fmt, mpebp_pkg::BANK_BASE + 32'h31, 48'h3);
    check(48'({d_master, seen_wr}), 48'h3);
    // Rotating priority yields to the other party though the device asks.
    @(posedge clk);
    #1;
    rot = 1'b1;
    o_want = 1'b1;
    d_valid = 1'b1;
    n = 0;
    repeat (3) @(negedge clk) n += int'(d_master === 1'b0);
    @(posedge clk);
    #1;
    d_valid = 1'b0;
    o_want = 1'b0;
    check(48'(n != 0), 48'h1);
    finish_test();
  end
endmodule : multiprocessor_external_bus_port_test
